// ===== hdl/eg_top.sv
// encoder position counter and line acquisition gate with avalon-mm registers
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "eg_consts.svh"
module eg_top (
    // clock and reset
    input  wire logic                   MCLK,
    input  wire logic                   RST_N,
    // avalon-mm slave
    input  wire logic [`EG_ADDR_W-1:0]  AVS_ADDRESS,
    input  wire logic                   AVS_READ,
    input  wire logic                   AVS_WRITE,
    input  wire logic [31:0]            AVS_WRITEDATA,
    input  wire logic [3:0]             AVS_BYTEENABLE,
    output logic      [31:0]            AVS_READDATA,
    output logic                        AVS_WAITREQUEST,
    // encoder phases
    input  wire logic                   ENC_A,
    input  wire logic                   ENC_B,
    // acquisition engine
    output logic                        LINE_ACQUIRE,
    output logic                        LINE_DIR,
    output eg_pkg::eg_pos_t             POSITION,
    output logic                        TRIG_FROM_STEP,
    // encoder divider control
    output logic                        DIV_STALL_ON_SLOW,
    output logic                        DIV_FREE_RUN,
    output eg_pkg::eg_refsel_t          DIV_REF_CLOCK_SELECT
);
    import eg_pkg::*;

    function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [31:0] acq_ctrl_reg;
    logic [31:0] win_ctrl_reg;
    eg_pos_t     pos_reg;
    logic [31:0] line_cnt_reg;
    logic        a_prev_reg;
    logic        b_prev_reg;
    eg_pos_t     vis_min_reg;
    eg_pos_t     vis_max_reg;
    logic        vis_valid_reg;

    // bus decode, one wait state per access
    wire         req       = AVS_READ | AVS_WRITE;
    wire         bus_done  = req & ~AVS_WAITREQUEST;
    wire         wr_acq    = bus_done & AVS_WRITE & (AVS_ADDRESS == `EG_OFS_ACQ_CTRL);
    wire         wr_win    = bus_done & AVS_WRITE & (AVS_ADDRESS == `EG_OFS_WIN_CTRL);
    wire  [31:0] acq_merge = be_merge(acq_ctrl_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
    wire  [31:0] win_merge = be_merge(win_ctrl_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
    wire  [31:0] acq_next  = wr_acq ? (acq_merge & ~`EG_WO_MASK_ACQ) : acq_ctrl_reg;
    wire  [31:0] win_next  = wr_win ? (win_merge & ~`EG_WO_MASK_WIN) : win_ctrl_reg;
    wire         sys_clr   = wr_acq & AVS_BYTEENABLE[3] & AVS_WRITEDATA[`EG_SYS_CLR_BIT];
    wire         vl_clr    = wr_win & AVS_BYTEENABLE[3] & AVS_WRITEDATA[`EG_VIS_CLR_BIT];
    wire  [31:0] rd_mux    = (AVS_ADDRESS == `EG_OFS_ACQ_CTRL) ? acq_ctrl_reg :
                             (AVS_ADDRESS == `EG_OFS_WIN_CTRL) ? win_ctrl_reg :
                             (AVS_ADDRESS == `EG_OFS_POS_STAT) ? {7'h00, vis_valid_reg, pos_reg} :
                             (AVS_ADDRESS == `EG_OFS_LINE_CNT) ? line_cnt_reg : 32'h0000_0000;

    // control fields
    eg_pos_t      lower_lim;
    eg_pos_t      upper_lim;
    eg_dir_t      acq_dir;
    eg_clr_mode_t clr_mode;
    assign lower_lim = acq_ctrl_reg[`EG_LIMIT_MSB:0];
    assign upper_lim = win_ctrl_reg[`EG_LIMIT_MSB:0];
    assign acq_dir   = eg_dir_t'(acq_ctrl_reg[`EG_AQDIR_LSB +: 2]);
    assign clr_mode  = eg_clr_mode_t'(win_ctrl_reg[`EG_CLR_MODE_LSB +: 2]);
    wire   dec4x     = acq_ctrl_reg[`EG_DECODE_BIT];
    wire   win_en    = acq_ctrl_reg[`EG_WIN_EN_BIT];
    wire   single    = acq_ctrl_reg[`EG_SINGLE_BIT];
    wire   dual      = acq_ctrl_reg[`EG_DUAL_BIT];

    // edge decode
    wire   a_rise    = ENC_A & ~a_prev_reg;
    wire   b_rise    = ENC_B & ~b_prev_reg;
    wire   a_chg     = ENC_A ^ a_prev_reg;
    wire   b_chg     = ENC_B ^ b_prev_reg;
    wire   cnt_a     = dec4x ? a_chg : a_rise;
    wire   cnt_b     = dec4x ? b_chg : b_rise;
    wire   quad_step = (cnt_a & ~b_chg) | (cnt_b & ~a_chg);
    wire   quad_up   = cnt_a ? (ENC_A != ENC_B) : (ENC_A == ENC_B);
    wire   step_ev   = dual ? quad_step : cnt_a;
    wire   step_up   = dual ? quad_up : 1'b1;
    eg_pos_t pos_next;
    assign pos_next  = step_up ? pos_reg + 24'h00_0001 : pos_reg - 24'h00_0001;

    // acquisition filters
    wire   dir_ok    = (acq_dir == EG_DIR_BOTH) | ((acq_dir == EG_DIR_UP) & step_up)
                     | ((acq_dir == EG_DIR_DOWN) & ~step_up);
    wire   in_win    = ~win_en | ((pos_next >= lower_lim) & (pos_next <= upper_lim));
    wire   new_val   = ~vis_valid_reg | (pos_next > vis_max_reg) | (pos_next < vis_min_reg);
    wire   visit_ok  = ~single | new_val;
    wire   acq_ev    = step_ev & dir_ok & in_win & visit_ok & ~sys_clr;
    wire   above     = pos_reg > upper_lim;
    wire   below     = pos_reg < lower_lim;
    wire   auto_clr  = (clr_mode == EG_CLR_AUTO)
                     & (((acq_dir != EG_DIR_DOWN) & above) | ((acq_dir != EG_DIR_UP) & below));
    wire   vis_clr   = sys_clr | vl_clr | auto_clr;

    // bus slave
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h0000_0000;
        end else begin
            AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
            AVS_READDATA    <= (req & AVS_WAITREQUEST & AVS_READ) ? rd_mux : 32'h0000_0000;
        end
    end

    // control words and divider outputs
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            acq_ctrl_reg         <= `EG_RST_ACQ_CTRL;
            win_ctrl_reg         <= `EG_RST_WIN_CTRL;
            TRIG_FROM_STEP       <= 1'b0;
            DIV_STALL_ON_SLOW    <= 1'b0;
            DIV_FREE_RUN         <= 1'b0;
            DIV_REF_CLOCK_SELECT <= 3'h0;
        end else begin
            acq_ctrl_reg         <= acq_next;
            win_ctrl_reg         <= win_next;
            TRIG_FROM_STEP       <= acq_next[`EG_STEP_TRIG_BIT];
            DIV_STALL_ON_SLOW    <= win_next[`EG_STALL_BIT];
            DIV_FREE_RUN         <= win_next[`EG_FREE_RUN_BIT];
            DIV_REF_CLOCK_SELECT <= win_next[`EG_REFSEL_LSB +: 3];
        end
    end

    // position counter and line events
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            a_prev_reg   <= 1'b0;
            b_prev_reg   <= 1'b0;
            pos_reg      <= 24'h00_0000;
            line_cnt_reg <= 32'h0000_0000;
            LINE_ACQUIRE <= 1'b0;
            LINE_DIR     <= 1'b0;
        end else begin
            a_prev_reg   <= ENC_A;
            b_prev_reg   <= ENC_B;
            LINE_ACQUIRE <= acq_ev;
            LINE_DIR     <= acq_ev ? step_up : LINE_DIR;
            if (sys_clr) begin
                pos_reg      <= 24'h00_0000;
                line_cnt_reg <= 32'h0000_0000;
            end else begin
                pos_reg      <= step_ev ? pos_next : pos_reg;
                line_cnt_reg <= acq_ev ? line_cnt_reg + 32'h0000_0001 : line_cnt_reg;
            end
        end
    end
    assign POSITION = pos_reg;

    // visited span, an acquisition beats a clear in the same cycle
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            vis_valid_reg <= 1'b0;
            vis_min_reg   <= 24'h00_0000;
            vis_max_reg   <= 24'h00_0000;
        end else if (acq_ev) begin
            vis_valid_reg <= 1'b1;
            vis_min_reg   <= (vis_clr | ~vis_valid_reg | (pos_next < vis_min_reg)) ? pos_next : vis_min_reg;
            vis_max_reg   <= (vis_clr | ~vis_valid_reg | (pos_next > vis_max_reg)) ? pos_next : vis_max_reg;
        end else if (vis_clr) begin
            vis_valid_reg <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    AST_TWO_X_RISING: assert property (
        (!dec4x && (a_chg || b_chg) && !a_rise && !b_rise && !sys_clr) |=> $stable(pos_reg))
        else $error("2x decode moved counter on a falling edge");
    AST_FOUR_X_FALL: assert property (
        (dec4x && dual && a_chg && !ENC_A && !b_chg && !sys_clr) |=> (pos_reg != $past(pos_reg)))
        else $error("4x decode missed a falling edge");
    AST_DIR_FILTER: assert property (
        (acq_ev && acq_dir == EG_DIR_UP) |=> (LINE_ACQUIRE && LINE_DIR))
        else $error("up-only acquisition gave a down line");
    AST_DIR_RSVD: assert property (
        (acq_dir == EG_DIR_RSVD) |=> !LINE_ACQUIRE)
        else $error("line acquired with reserved direction");
    AST_WINDOW: assert property (
        (step_ev && win_en && !sys_clr && ((pos_next < lower_lim) || (pos_next > upper_lim)))
        |=> !LINE_ACQUIRE)
        else $error("line acquired outside the window");
    AST_LOWER_LIMIT: assert property (
        (wr_acq && AVS_BYTEENABLE == 4'hf) |=> (lower_lim == $past(AVS_WRITEDATA[23:0])))
        else $error("lower limit not stored");
    AST_UPPER_LIMIT: assert property (
        (wr_win && AVS_BYTEENABLE == 4'hf) |=> (upper_lim == $past(AVS_WRITEDATA[23:0])))
        else $error("upper limit not stored");
    AST_NO_REVISIT: assert property (
        (step_ev && single && vis_valid_reg && !vis_clr && (pos_next >= vis_min_reg)
         && (pos_next <= vis_max_reg)) |=> !LINE_ACQUIRE)
        else $error("visited value acquired twice");
    AST_EVERY_STEP: assert property (
        (step_ev && !single && dir_ok && in_win && !sys_clr) |=> LINE_ACQUIRE)
        else $error("counter change without a line");
    AST_SYS_CLEAR: assert property (
        sys_clr |=> (pos_reg == 24'h00_0000 && !vis_valid_reg && !LINE_ACQUIRE))
        else $error("system clear left state behind");
    AST_LIST_CLEAR: assert property (
        (vl_clr && !acq_ev) |=> !vis_valid_reg)
        else $error("visited clear ignored");
    AST_AUTO_CLEAR: assert property (
        (clr_mode == EG_CLR_AUTO && acq_dir == EG_DIR_UP && above && !acq_ev) |=> !vis_valid_reg)
        else $error("auto clear missed above the window");
    AST_SINGLE_PHASE: assert property (
        (!dual && b_chg && !a_chg && !sys_clr) |=> $stable(pos_reg))
        else $error("single phase counted input B");
    AST_DIV_BITS: assert property (
        wr_win |=> (DIV_STALL_ON_SLOW == win_ctrl_reg[`EG_STALL_BIT]
                    && DIV_FREE_RUN == win_ctrl_reg[`EG_FREE_RUN_BIT]
                    && TRIG_FROM_STEP == acq_ctrl_reg[`EG_STEP_TRIG_BIT]))
        else $error("divider or trigger output out of step");
    AST_QUAD_DOWN: assert property (
        (dual && dec4x && a_rise && ENC_B && !b_chg && !sys_clr) |=> (pos_reg == $past(pos_reg) - 24'h00_0001))
        else $error("quadrature B-leading did not count down");
    AST_BUS_ONE_WAIT: assert property (
        (req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus answer not after one wait state");

    AST_BUS_IDLE_WAIT: assert property (
        (!req && AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
        else $error("waitrequest dropped without a request");

    AST_READ_IDLE_ZERO: assert property (
        AVS_WAITREQUEST |-> (AVS_READDATA == 32'h0000_0000))
        else $error("read data not zero outside an answer");

    AST_READ_UNMAPPED: assert property (
        (req && AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS >= 5'h10) |=> (AVS_READDATA == 32'h0000_0000))
        else $error("unmapped address read not zero");

    AST_READ_POSITION: assert property (
        (req && AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS == `EG_OFS_POS_STAT)
        |=> (AVS_READDATA[23:0] == $past(pos_reg)))
        else $error("status read lost the position");

    AST_WO_SYS_CLEAR: assert property (
        !acq_ctrl_reg[`EG_SYS_CLR_BIT])
        else $error("system clear bit stored");

    AST_WO_LIST_CLEAR: assert property (
        !win_ctrl_reg[`EG_VIS_CLR_BIT])
        else $error("visited clear bit stored");

    AST_POS_HOLD: assert property (
        (!step_ev && !sys_clr) |=> $stable(pos_reg))
        else $error("counter moved without a counted edge");

    AST_NO_STEP_NO_LINE: assert property (
        !step_ev |=> !LINE_ACQUIRE)
        else $error("line acquired without a counter change");

    AST_SINGLE_UP: assert property (
        (!dec4x && !dual && a_rise && !sys_clr) |=> (pos_reg == $past(pos_reg) + 24'h00_0001))
        else $error("single phase rising edge not counted up");

    AST_FOUR_X_B_FALL: assert property (
        (dec4x && dual && b_chg && !ENC_B && !a_chg && !sys_clr) |=> (pos_reg != $past(pos_reg)))
        else $error("4x decode missed a falling edge of B");

    AST_QUAD_UP: assert property (
        (dual && a_rise && !ENC_B && !b_chg && !sys_clr) |=> (pos_reg == $past(pos_reg) + 24'h00_0001))
        else $error("quadrature A-leading did not count up");

    AST_DIR_DOWN: assert property (
        (acq_ev && acq_dir == EG_DIR_DOWN) |=> (LINE_ACQUIRE && !LINE_DIR))
        else $error("down-only acquisition gave an up line");

    AST_WIN_INSIDE: assert property (
        (acq_ev && win_en && !wr_acq && !wr_win)
        |=> (LINE_ACQUIRE && POSITION >= lower_lim && POSITION <= upper_lim))
        else $error("window line taken outside the limits");

    AST_LINE_COUNT: assert property (
        (acq_ev && !sys_clr) |=> (line_cnt_reg == $past(line_cnt_reg) + 32'h0000_0001))
        else $error("acquired line not counted");

    AST_VIS_SPAN: assert property (
        vis_valid_reg |-> (vis_min_reg <= vis_max_reg))
        else $error("visited span inverted");

    AST_VIS_SET: assert property (
        acq_ev |=> vis_valid_reg)
        else $error("acquired value not recorded");

    AST_MANUAL_KEEP: assert property (
        (clr_mode == EG_CLR_MANUAL && vis_valid_reg && !vl_clr && !sys_clr) |=> vis_valid_reg)
        else $error("manual mode record cleared without a write");

    AST_AUTO_BELOW: assert property (
        (clr_mode == EG_CLR_AUTO && acq_dir == EG_DIR_DOWN && below && !acq_ev) |=> !vis_valid_reg)
        else $error("auto clear missed below the window");

    AST_REFSEL_COPY: assert property (
        DIV_REF_CLOCK_SELECT == win_ctrl_reg[`EG_REFSEL_LSB +: 3])
        else $error("reference select output out of step");

    CVR_WIN_TOP:    cover property (acq_ev && win_en && pos_next == upper_lim);

    CVR_UP_LINE:    cover property (LINE_ACQUIRE && LINE_DIR);
    CVR_DOWN_LINE:  cover property (LINE_ACQUIRE && !LINE_DIR);
    CVR_REVISIT:    cover property (step_ev && single && !new_val);
    CVR_AUTO_CLEAR: cover property (auto_clr && vis_valid_reg);
endmodule

// ===== hdl/eg_consts.svh
// register map, field positions and reset values of the encoder line gate
`ifndef EG_CONSTS_SVH
`define EG_CONSTS_SVH
`define EG_ADDR_W        5
`define EG_OFS_ACQ_CTRL  5'h00
`define EG_OFS_WIN_CTRL  5'h04
`define EG_OFS_POS_STAT  5'h08
`define EG_OFS_LINE_CNT  5'h0c
`define EG_RST_ACQ_CTRL  32'h0000_0000
`define EG_RST_WIN_CTRL  32'h0000_0000
`define EG_LIMIT_MSB     23
`define EG_DECODE_BIT    24
`define EG_AQDIR_LSB     25
`define EG_WIN_EN_BIT    27
`define EG_SINGLE_BIT    28
`define EG_DUAL_BIT      29
`define EG_STEP_TRIG_BIT 30
`define EG_SYS_CLR_BIT   31
`define EG_CLR_MODE_LSB  24
`define EG_VIS_CLR_BIT   26
`define EG_STALL_BIT     27
`define EG_FREE_RUN_BIT  28
`define EG_REFSEL_LSB    29
`define EG_WO_MASK_ACQ   32'h8000_0000
`define EG_WO_MASK_WIN   32'h0400_0000
`endif

// ===== hdl/eg_pkg.sv
// types shared by the encoder line gate
package eg_pkg;
    typedef logic [23:0] eg_pos_t;
    typedef logic [2:0]  eg_refsel_t;
    typedef enum logic [1:0] {
        EG_DIR_BOTH = 2'b00,
        EG_DIR_UP   = 2'b01,
        EG_DIR_DOWN = 2'b10,
        EG_DIR_RSVD = 2'b11
    } eg_dir_t;
    typedef enum logic [1:0] {
        EG_CLR_MANUAL = 2'b00,
        EG_CLR_AUTO   = 2'b01,
        EG_CLR_RSVD2  = 2'b10,
        EG_CLR_RSVD3  = 2'b11
    } eg_clr_mode_t;
endpackage

// ===== sim/eg_enc_model.sv
// quadrature encoder model driving the two phase lines
`timescale 1ns/1ps
module eg_enc_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // step request
    input  wire logic step,
    input  wire logic up,
    // phases
    output logic      pha,
    output logic      phb
);
    logic [1:0] st_reg;
    // gray order 00,10,11,01 going up: phase a leads phase b; levels held between steps
    always_ff @(posedge clk) begin
        if (!rst_n)
            st_reg <= 2'h0;
        else if (step)
            st_reg <= up ? st_reg + 2'h1 : st_reg - 2'h1;
    end
    assign pha = st_reg[1] ^ st_reg[0];
    assign phb = st_reg[1];
endmodule

// ===== sim/eg_top_tb.sv
// self-checking bench of the encoder line gate against a behavioural model
`timescale 1ns/1ps
`include "eg_consts.svh"
module eg_top_tb;
    import eg_pkg::*;
    logic        MCLK, RST_N, rd, wr, stp, sup, ENC_A, ENC_B, LINE_ACQUIRE, LINE_DIR, wq;
    logic        TRIG_FROM_STEP, DIV_STALL_ON_SLOW, DIV_FREE_RUN;
    logic [4:0]  adr;
    logic [3:0]  be;
    logic [31:0] wd, rdata, q, w1, w2;
    logic [15:0] lfsr;
    eg_pos_t     POSITION;
    eg_refsel_t  DIV_REF_CLOCK_SELECT;
    int          fails, n_compared, nacq = 0, nexp, base, pos, lo, hi, vmin, vmax;
    bit          pa, pb, vv, ldir, dec, q1, win, sv, am, trig, stall, free;
    bit [1:0]    dir;

    eg_top dut (.MCLK(MCLK), .RST_N(RST_N), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq),
        .ENC_A(ENC_A), .ENC_B(ENC_B), .LINE_ACQUIRE(LINE_ACQUIRE), .LINE_DIR(LINE_DIR),
        .POSITION(POSITION), .TRIG_FROM_STEP(TRIG_FROM_STEP), .DIV_STALL_ON_SLOW(DIV_STALL_ON_SLOW),
        .DIV_FREE_RUN(DIV_FREE_RUN), .DIV_REF_CLOCK_SELECT(DIV_REF_CLOCK_SELECT));
    eg_enc_model enc (.clk(MCLK), .rst_n(RST_N), .step(stp), .up(sup), .pha(ENC_A), .phb(ENC_B));

    always @(posedge MCLK) if (LINE_ACQUIRE === 1'b1) nacq <= nacq + 1;

    function automatic int rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return int'(lfsr);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // avalon-mm master: hold the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] e);
        int n;
        n = 0;
        @(posedge MCLK);
        adr <= a;
        wd  <= d;
        be  <= e;
        wr  <= w;
        rd  <= !w;
        do begin
            @(posedge MCLK);
            n++;
        end while (wq !== 1'b0 && n < 20);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 20) fails++;
    endtask

    task automatic step(input bit u);
        bit ea, eb, cnt, upd, acq;
        @(posedge MCLK);
        stp <= 1'b1;
        sup <= u;
        @(posedge MCLK);
        stp <= 1'b0;
        @(posedge MCLK);
        ea = ENC_A != pa;
        eb = ENC_B != pb;
        pa = ENC_A;
        pb = ENC_B;
        cnt = !(ea && eb) && ((ea && (dec || pa)) || (q1 && eb && (dec || pb)));
        upd = !q1 || (ea ? pa != pb : pa == pb);
        if (cnt) pos = (pos + (upd ? 1 : -1)) & 32'hff_ffff;
        acq = cnt && dir != 3 && (dir == 0 || (dir == 1) == upd) && (!win || (pos >= lo && pos <= hi))
              && !(sv && vv && pos >= vmin && pos <= vmax);
        if (acq) begin
            nexp++;
            ldir = upd;
            vmin = (vv && vmin < pos) ? vmin : pos;
            vmax = (vv && vmax > pos) ? vmax : pos;
            vv = 1;
        end
        if (am && ((dir < 2 && pos > hi) || (dir != 1 && pos < lo))) vv = 0;
        repeat (4) @(posedge MCLK);
        chk(32'(POSITION), pos);
        chk(nacq, nexp);
        if (nexp > 0) chk(32'(LINE_DIR), 32'(ldir));
    endtask

    task automatic cfg(input int i);
        while (ENC_A || ENC_B) step(1'b1);
        dec = i[0];
        q1 = i[1];
        dir = 2'(i >> 2);
        {win, sv, am, trig, stall, free} = 6'(rnd());
        lo = 2 + rnd() % 3;
        hi = lo + 4 + rnd() % 4;
        w2 = {3'h0, free, stall, 1'b1, 1'b0, am, 24'(hi)};
        w1 = {1'b0, trig, q1, sv, win, dir, dec, 24'(lo)};
        bus(1'b1, `EG_OFS_WIN_CTRL, w2, 4'hf);
        bus(1'b1, `EG_OFS_ACQ_CTRL, w1, 4'hf);
        bus(1'b1, `EG_OFS_ACQ_CTRL, w1 | 32'h8000_0000, 4'hf);
        pos = 0;
        vv = 0;
        base = nexp;
        bus(1'b0, `EG_OFS_ACQ_CTRL, 32'h0, 4'hf);
        chk(q, w1);
        bus(1'b0, `EG_OFS_WIN_CTRL, 32'h0, 4'hf);
        chk(q, w2 & 32'hfbff_ffff);
        bus(1'b0, `EG_OFS_POS_STAT, 32'h0, 4'hf);
        chk(q, 32'h0);
        chk({TRIG_FROM_STEP, DIV_STALL_ON_SLOW, DIV_FREE_RUN, DIV_REF_CLOCK_SELECT}, {trig, stall, free, 3'h0});
        for (int k = 0; k < 30; k++) begin
            if (k == 15) begin
                bus(1'b1, `EG_OFS_WIN_CTRL, w2, 4'hf);
                vv = 0;
            end
            step(rnd() % 8 < 5);
        end
        bus(1'b0, `EG_OFS_LINE_CNT, 32'h0, 4'hf);
        chk(q, nexp - base);
        bus(1'b0, `EG_OFS_POS_STAT, 32'h0, 4'hf);
        chk(q & {7'h0, sv, 24'hff_ffff}, {7'h0, sv && vv, 24'(pos)});
        $display("config %0d done", i);
    endtask

    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    initial begin
        repeat (40000) @(posedge MCLK);
        fails++;
        report_and_stop();
    end

    initial begin
        {RST_N, rd, wr, stp, sup, pa, pb} = '0;
        {adr, be, wd} = '0;
        {fails, n_compared, nexp} = '0;
        lfsr = 16'h0060;
        repeat (4) @(posedge MCLK);
        RST_N <= 1'b1;
        bus(1'b1, 5'h10, 32'hffff_ffff, 4'hf);
        for (int a = 0; a < 20; a += 4) begin
            bus(1'b0, 5'(a), 32'h0, 4'hf);
            chk(q, 32'h0);
        end
        bus(1'b1, `EG_OFS_ACQ_CTRL, 32'h7fff_ffff, 4'h1);
        bus(1'b0, `EG_OFS_ACQ_CTRL, 32'h0, 4'hf);
        chk(q, 32'h0000_00ff);
        $display("register test done");
        for (int i = 0; i < 32; i++) cfg(i);
        report_and_stop();
    end
endmodule
